// File: verilog/dss_port.sv
// Contract
// - Write data sampled on K and K# rises
// - Strobe low captures address and direction
// - Every transaction moves exactly two words
// - Byte gates sampled with their data word
// - Deasserted gate leaves stored byte unchanged
// - Address captured only on K rise
// - 22 address bits, two 18-bit halves
// - Address ignored when port not selected
// - Read words launched on C and C# rises
// - Outputs float by themselves when idle
// - Direction high reads, low writes
// - Accesses start only on K rise
// - Single-clock mode launches on K, K#
// - Free-running echo clocks follow output clock
// - Loop-off strap low selects legacy timing
// - Latency 1.5 cycles, or 1 loop off
// - Lower-order word comes out first
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "dss_map.svh"
module dss_port #(
	parameter int MEM_AW = `DSS_ADDR_W           // Decoded address bits
) (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	// AHB-Lite slave
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	// Memory pins
	input  wire logic                         k,
	input  wire logic                         k_n,
	input  wire logic                         c,
	input  wire logic                         c_n,
	input  wire logic                         transaction_strobe_n,
	input  wire logic                         rw,
	input  wire logic                         loop_off_n,
	input  wire logic [`DSS_ADDR_W-1:0]       addr,
	input  wire logic [`DSS_WORD_W-1:0]       d,
	input  wire logic [1:0]                   byte_gate_n,
	output logic [`DSS_WORD_W-1:0]            q,
	output logic                              q_oe,
	output logic                              echo_strobe,
	output logic                              echo_strobe_n
);
	import dss_pkg::*;

	// ****************************************************************
	// State, next state and the array
	// ****************************************************************
	dss_state_t               st;                  // Registered state
	dss_state_t               next_st;             // Next value of it
	dss_pins_t                pins;                // Raw pin bundle
	// Two halves: word 0 and word 1 of every location
	logic [`DSS_WORD_W-1:0]   mem_lo [2**MEM_AW];
	logic [`DSS_WORD_W-1:0]   mem_hi [2**MEM_AW];
	logic                     mem_we;              // Commit the pair
	logic [MEM_AW-1:0]        mem_wa;              // Commit location
	logic [MEM_AW-1:0]        mem_ra;              // Read location

	// Gather the pins into one bundle
	always_comb begin
		pins.k                    = k;
		pins.k_n                  = k_n;
		pins.c                    = c;
		pins.c_n                  = c_n;
		pins.transaction_strobe_n = transaction_strobe_n;
		pins.rw                   = rw;
		pins.loop_off_n           = loop_off_n;
		pins.addr                 = addr;
		pins.d                    = d;
		pins.byte_gate_n          = byte_gate_n;
	end

	// Address bits beyond the array are dropped here,
	// so a shallow array aliases rather than faults
	assign mem_ra = st.rd_addr[MEM_AW-1:0];
	assign mem_wa = st.wr_addr[MEM_AW-1:0];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [3:0] rise;                          // k, k_n, c, c_n rises
		logic       pos_ev;                        // Output positive edge
		logic       neg_ev;                        // Output negative edge
		logic       emitted;                       // Word launched now
		logic       live;                          // Straps known
		logic [31:0] rd_word;                      // Bus read value
		rise    = 4'h0;
		pos_ev  = 1'b0;
		neg_ev  = 1'b0;
		emitted = 1'b0;
		live    = 1'b0;
		rd_word = 32'h0000_0000;
		next_st = st;
		mem_we  = 1'b0;

		// Pins are slow against hclk: each level is seen three
		// times, so a spike shorter than one clock never
		// counts as a clock edge
		// Three stages; stage 1 feeds stage 2 only
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;

		// A clock level counts once stages 2 and 3 agree
		if (st.s2.k == st.s3.k) begin
			next_st.fclk[3] = st.s3.k;
		end
		if (st.s2.k_n == st.s3.k_n) begin
			next_st.fclk[2] = st.s3.k_n;
		end
		if (st.s2.c == st.s3.c) begin
			next_st.fclk[1] = st.s3.c;
		end
		if (st.s2.c_n == st.s3.c_n) begin
			next_st.fclk[0] = st.s3.c_n;
		end
		rise = next_st.fclk & ~st.fclk;

		// Straps caught once the stages are full
		if (!st.strap_done) begin
			if (st.settle == `DSS_SETTLE_CYCLES) begin
				next_st.strap_done = 1'b1;
				next_st.single_clk = st.s3.c & st.s3.c_n;
				next_st.loop_on    = st.s3.loop_off_n;
				next_st.fclk       = {st.s3.k, st.s3.k_n, st.s3.c, st.s3.c_n};
			end else begin
				next_st.settle = st.settle + 2'h1;
			end
		end else begin
			live = 1'b1;
		end

		// Output edges come from C pair or, single-clock, from K pair
		if (live) begin
			pos_ev = st.single_clk ? rise[3] : rise[1];
			neg_ev = st.single_clk ? rise[2] : rise[0];
			// Echo pair free-runs beside the output clock
			next_st.echo_strobe   = st.single_clk ? next_st.fclk[3] : next_st.fclk[1];
			next_st.echo_strobe_n = st.single_clk ? next_st.fclk[2] : next_st.fclk[0];
		end

		// Launch runs before the fetch below, so a fetch on the
		// same edge may refill the buffer behind the last word
		// Launch the next queued word on its own edge
		if (st.orem != 2'h0 && ((pos_ev && !st.odue_neg) || (neg_ev && st.odue_neg))) begin
			next_st.q        = st.obuf[`DSS_WORD_W-1:0];
			next_st.obuf     = {{`DSS_WORD_W{1'b0}}, st.obuf[2*`DSS_WORD_W-1:`DSS_WORD_W]};
			next_st.orem     = st.orem - 2'h1;
			next_st.odue_neg = ~st.odue_neg;
			next_st.q_oe     = 1'b1;
			emitted          = 1'b1;
		end else if ((pos_ev || neg_ev) && st.orem == 2'h0) begin
			// Nothing left: float the outputs without any enable pin
			next_st.q_oe = 1'b0;
		end

		// Input side: everything starts on a K rise
		if (live && rise[3]) begin
			// Armed read: fetch both words of the location
			if (st.rd_arm) begin
				next_st.obuf     = {mem_hi[mem_ra], mem_lo[mem_ra]};
				next_st.orem     = 2'h2;
				next_st.odue_neg = st.loop_on;
				next_st.rd_arm   = 1'b0;
				// Loop off: first word goes out on this very edge if the output clock rises with it
				if (!st.loop_on && pos_ev && !emitted) begin
					next_st.q        = mem_lo[mem_ra];
					next_st.obuf     = {{`DSS_WORD_W{1'b0}}, mem_hi[mem_ra]};
					next_st.orem     = 2'h1;
					next_st.odue_neg = 1'b1;
					next_st.q_oe     = 1'b1;
				end
			end
			// Armed write: first data word and its gates
			if (st.wr_arm) begin
				next_st.wr_phase = 1'b1;
				next_st.wr_addr  = st.wr_arm_addr;
				next_st.wr_w0    = st.s3.d;
				next_st.wr_g0    = st.s3.byte_gate_n;
				next_st.wr_arm   = 1'b0;
			end
			// New transaction only while the strobe is low
			if (!st.s3.transaction_strobe_n && st.port_en) begin
				if (st.s3.rw) begin
					next_st.rd_arm   = 1'b1;
					next_st.rd_addr  = st.s3.addr;
					next_st.rd_count = st.rd_count + 16'h0001;
				end else begin
					next_st.wr_arm      = 1'b1;
					next_st.wr_arm_addr = st.s3.addr;
					next_st.wr_count    = st.wr_count + 16'h0001;
				end
			end
		end

		// Word 1 is not buffered: the commit reads the third
		// stage directly, which still holds it in this cycle
		// Second write word on the K# rise, then the pair commits
		if (live && rise[2] && st.wr_phase) begin
			mem_we           = 1'b1;
			next_st.wr_phase = 1'b0;
		end

		// ****************************************************************
		// AHB-Lite slave, zero wait states
		// ****************************************************************
		// Never stalls, so a read answers in the next cycle;
		// hsize is not checked and narrow writes act as words
		next_st.hreadyout = 1'b1;
		next_st.hresp     = 1'b0;
		// Data phase of a write
		if (st.bus_wr_pend) begin
			if (st.bus_addr == `DSS_OFF_CTRL) begin
				next_st.port_en = hwdata[`DSS_CTRL_EN_BIT];
			end
			next_st.bus_wr_pend = 1'b0;
		end
		// Address phase
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				next_st.bus_wr_pend = 1'b1;
				next_st.bus_addr    = haddr[7:0];
			end else begin
				if (haddr[7:0] == `DSS_OFF_CTRL) begin
					rd_word[`DSS_CTRL_EN_BIT] = next_st.port_en;
				end else if (haddr[7:0] == `DSS_OFF_STATUS) begin
					rd_word[`DSS_ST_READY_BIT]  = st.strap_done;
					rd_word[`DSS_ST_SINGLE_BIT] = st.single_clk;
					rd_word[`DSS_ST_LOOP_BIT]   = st.loop_on;
					rd_word[`DSS_ST_RBUSY_BIT]  = st.rd_arm | (st.orem != 2'h0);
					rd_word[`DSS_ST_WBUSY_BIT]  = st.wr_arm | st.wr_phase;
				end else if (haddr[7:0] == `DSS_OFF_RDCNT) begin
					rd_word[15:0] = st.rd_count;
				end else if (haddr[7:0] == `DSS_OFF_WRCNT) begin
					rd_word[15:0] = st.wr_count;
				end else begin
					// Unmapped: reads zero
					rd_word = 32'h0000_0000;
				end
				next_st.hrdata = rd_word;
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset clears the stages too; the strap counter then
	// waits until they hold real pin levels again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st           <= '0;
			st.port_en   <= `DSS_CTRL_RESET;
			st.hreadyout <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Array commit, one gate per nine-bit lane
	// ****************************************************************
	// No reset: a real array powers up with unknown contents
	always_ff @(posedge hclk) begin
		if (mem_we) begin
			if (!st.wr_g0[0]) begin
				mem_lo[mem_wa][`DSS_LANE_W-1:0] <= st.wr_w0[`DSS_LANE_W-1:0];
			end
			if (!st.wr_g0[1]) begin
				mem_lo[mem_wa][`DSS_WORD_W-1:`DSS_LANE_W] <= st.wr_w0[`DSS_WORD_W-1:`DSS_LANE_W];
			end
			if (!st.s3.byte_gate_n[0]) begin
				mem_hi[mem_wa][`DSS_LANE_W-1:0] <= st.s3.d[`DSS_LANE_W-1:0];
			end
			if (!st.s3.byte_gate_n[1]) begin
				mem_hi[mem_wa][`DSS_WORD_W-1:`DSS_LANE_W] <= st.s3.d[`DSS_WORD_W-1:`DSS_LANE_W];
			end
		end
	end

	// ****************************************************************
	// Outputs straight from the state register
	// ****************************************************************
	// Each output is a plain copy of a state bit: no logic
	// sits between the register and the pin
	assign hreadyout     = st.hreadyout;
	assign hresp         = st.hresp;
	assign hrdata        = st.hrdata;
	assign q             = st.q;
	assign q_oe          = st.q_oe;
	assign echo_strobe   = st.echo_strobe;
	assign echo_strobe_n = st.echo_strobe_n;
endmodule : dss_port
`default_nettype wire

// File: common/dss_map.svh
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH
// ****************************************************************
// Widths of the memory pins
// ****************************************************************
`define DSS_ADDR_W        22
`define DSS_WORD_W        18
`define DSS_LANE_W        9
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DSS_OFF_CTRL      8'h00
`define DSS_OFF_STATUS    8'h04
`define DSS_OFF_RDCNT     8'h08
`define DSS_OFF_WRCNT     8'h0C
// ****************************************************************
// Field positions
// ****************************************************************
`define DSS_CTRL_EN_BIT   0
`define DSS_ST_READY_BIT  0
`define DSS_ST_SINGLE_BIT 1
`define DSS_ST_LOOP_BIT   2
`define DSS_ST_RBUSY_BIT  3
`define DSS_ST_WBUSY_BIT  4
// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define DSS_CTRL_RESET    1'b1
`define DSS_SETTLE_CYCLES 2'h3
`endif

// File: common/dss_pkg.sv
// ****************************************************************
// Types shared by the memory port
// ****************************************************************
`include "dss_map.svh"
`default_nettype none
package dss_pkg;
	// Pin inputs as sampled together
	typedef struct packed {
		logic                      k;
		logic                      k_n;
		logic                      c;
		logic                      c_n;
		logic                      transaction_strobe_n;
		logic                      rw;
		logic                      loop_off_n;
		logic [`DSS_ADDR_W-1:0]    addr;
		logic [`DSS_WORD_W-1:0]    d;
		logic [1:0]                byte_gate_n;
	} dss_pins_t;

	// Whole state of the port
	typedef struct packed {
		dss_pins_t                 s1;
		dss_pins_t                 s2;
		dss_pins_t                 s3;
		logic [3:0]                fclk;
		logic [1:0]                settle;
		logic                      strap_done;
		logic                      single_clk;
		logic                      loop_on;
		logic                      rd_arm;
		logic [`DSS_ADDR_W-1:0]    rd_addr;
		logic                      wr_arm;
		logic [`DSS_ADDR_W-1:0]    wr_arm_addr;
		logic                      wr_phase;
		logic [`DSS_ADDR_W-1:0]    wr_addr;
		logic [`DSS_WORD_W-1:0]    wr_w0;
		logic [1:0]                wr_g0;
		logic [2*`DSS_WORD_W-1:0]  obuf;
		logic [1:0]                orem;
		logic                      odue_neg;
		logic [`DSS_WORD_W-1:0]    q;
		logic                      q_oe;
		logic                      echo_strobe;
		logic                      echo_strobe_n;
		logic                      bus_wr_pend;
		logic [7:0]                bus_addr;
		logic [31:0]               hrdata;
		logic                      hreadyout;
		logic                      hresp;
		logic                      port_en;
		logic [15:0]               rd_count;
		logic [15:0]               wr_count;
	} dss_state_t;
endpackage : dss_pkg
`default_nettype wire

// File: bench/dss_port_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks
// ****
module dss_port_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        k,
	input wire logic        c,
	input wire logic        c_n,
	input wire logic        transaction_strobe_n,
	input wire logic        rw,
	input wire logic        q_oe,
	input wire logic        echo_strobe,
	input wire logic        echo_strobe_n
);
	import dss_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [5:0] idle; // Cycles since a read command, saturating
	// Saturation keeps a long idle spell from wrapping
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			idle <= 6'h3F;
		else if (!transaction_strobe_n && rw)
			idle <= 6'h00;
		else if (idle != 6'h3F)
			idle <= idle + 6'h01;
	end
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("error response");
	chk_rdata_cause: assert property ($changed(hrdata) |->
		$past(hsel && hready && htrans[1] && !hwrite)) else $error("hrdata moved");
	chk_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite &&
		haddr[7:0] > 8'h0C |=> hrdata == 32'h0000_0000) else $error("unmapped not 0");
	chk_echo_pos: assert property ($rose(c) && !c_n |-> ##[2:6] echo_strobe)
		else $error("echo missed c");
	chk_echo_neg: assert property ($rose(c_n) && !c |-> ##[2:6] echo_strobe_n)
		else $error("echo missed c_n");
	chk_echo_single: assert property (c && c_n && $rose(k) |-> ##[2:6] echo_strobe)
		else $error("echo missed k");
	chk_oe_cause: assert property ($rose(q_oe) |-> idle < 6'h28)
		else $error("q driven without read");
	chk_oe_idle: assert property (idle > 6'h30 |-> !q_oe)
		else $error("q not floated");
	chk_read_latency: assert property ($fell(transaction_strobe_n) && rw |->
		##[20:36] q_oe) else $error("read data late");
	cover property ($rose(q_oe));
	cover property (hsel && htrans[1] && hwrite);
	cover property (c && c_n && $rose(echo_strobe));
endmodule : dss_port_assertions
`default_nettype wire

// File: bench/dss_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Controller on the memory pins
// ****
module dss_ctl_model (
	input wire logic         hclk,
	input wire logic         single,
	output logic             k,
	output logic             k_n,
	output logic             c,
	output logic             c_n,
	output logic             strobe_n,
	output logic             rw,
	output logic [21:0]      addr,
	output logic [17:0]      d,
	output logic [1:0]       gate_n,
	input wire logic [17:0]  q,
	input wire logic         q_oe
);
	logic [3:0]  ph = 4'h0;          // Phase within one K period
	logic [62:0] cmdq[$];            // {rw, addr, w1, w0, gates}
	logic [17:0] got[$];             // Words seen on q
	logic [62:0] wp, wd;             // Pending, data phase
	logic        wpv = 1'b0;
	logic        wdv = 1'b0;
	initial {strobe_n, rw, addr, d, gate_n} = {2'h2, 22'h0, 18'h0, 2'h3};
	// K period of 16 hclk, so every level outlasts the 3-flop sampling
	assign k = ~ph[3];
	assign k_n = ph[3];
	assign c = single | k;
	assign c_n = single | k_n;
	task automatic send(input logic [62:0] x);
		cmdq.push_back(x);
	endtask : send
	// Pins move midway between clock rises (ph 4 and 12) and sit centred on each clock rise
	always @(posedge hclk) begin
		ph <= ph + 4'h1;
		if (ph == 4'hB) begin
			d <= wpv ? wp[21:4] : ~d;
			gate_n <= wpv ? wp[1:0] : ~gate_n;
			wd <= wp;
			wdv <= wpv;
			wpv <= 1'b0;
			if (cmdq.size() != 0) begin
				strobe_n <= 1'b0;
				rw <= cmdq[0][62];
				addr <= cmdq[0][61:40];
				wp <= cmdq[0];
				wpv <= !cmdq[0][62];
				cmdq.delete(0);
			end
		end
		// Released lines show the inverse, never the old value
		if (ph == 4'h3) begin
			strobe_n <= 1'b1;
			addr <= ~addr;
			rw <= ~rw;
			d <= wdv ? wd[39:22] : ~d;
			gate_n <= wdv ? wd[3:2] : ~gate_n;
		end
		if ((ph == 4'h6 || ph == 4'hE) && q_oe)
			got.push_back(q);
	end
endmodule : dss_ctl_model
`default_nettype wire

// File: bench/ddr_sio_sram_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ddr_sio_sram_port_bench;
	import dss_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        single = 1'b0, loff_n = 1'b1;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h3156_5469;
	logic        hreadyout, hresp, k, k_n, c, c_n, strobe_n, rw, q_oe, echo, echo_n;
	logic [21:0] addr;
	logic [17:0] d, q;
	logic [1:0]  gate_n;
	logic [7:0]  al[8];              // Test addresses, low bits distinct
	logic [35:0] mem[int];           // Reference array
	logic [17:0] expq[$];            // Expected read words in order
	int          num_errors = 0, checked = 0, nrd, nwr;
	// ****
	// Clock, design and controller
	// ****
	always #20 hclk = ~hclk;
	dss_port #(.MEM_AW(8)) u_dss_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.k(k), .k_n(k_n), .c(c), .c_n(c_n), .transaction_strobe_n(strobe_n), .rw(rw),
		.loop_off_n(loff_n), .addr(addr), .d(d), .byte_gate_n(gate_n), .q(q),
		.q_oe(q_oe), .echo_strobe(echo), .echo_strobe_n(echo_n));
	dss_ctl_model u_dss_ctl_model (.hclk(hclk), .single(single), .k(k), .k_n(k_n),
		.c(c), .c_n(c_n), .strobe_n(strobe_n), .rw(rw), .addr(addr), .d(d),
		.gate_n(gate_n), .q(q), .q_oe(q_oe));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic conclude;
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	// One AHB single transfer; read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n = 0;
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		if (n >= 50) begin num_errors++; conclude(); end
	endtask : bus
	// Write two words; en low means the port should refuse it
	task automatic mwr(input logic [7:0] a, input logic [35:0] w, input logic [3:0] g,
		input logic en);
		logic [35:0] m;
		m = mem.exists(a) ? mem[a] : 36'h0;
		for (int i = 0; i < 4; i++) if (!g[i]) m[i*9+:9] = w[i*9+:9];
		if (en) begin mem[a] = m; nwr++; end
		u_dss_ctl_model.send({1'b0, 14'h0, a, w, g});
	endtask : mwr
	task automatic mrd(input logic [7:0] a);
		u_dss_ctl_model.send({1'b1, 14'h0, a, 40'h0});
		expq.push_back(mem[a][17:0]);
		expq.push_back(mem[a][35:18]);
		nrd++;
	endtask : mrd
	// Wait for queued commands and their read words, then let writes land
	task automatic settle;
		int n = 0;
		while ((u_dss_ctl_model.cmdq.size() != 0 ||
			u_dss_ctl_model.got.size() < expq.size()) && n < 3000) begin
			@(posedge hclk);
			n++;
		end
		repeat (48) @(posedge hclk);
		if (n >= 3000) begin num_errors++; conclude(); end
	endtask : settle
	initial begin
		repeat (90000) @(posedge hclk);
		num_errors++;
		conclude();
	end
	// ****
	// Loop on, loop off, then single clock, each after its own reset
	// ****
	initial begin
		for (int m = 0; m < 3; m++) begin
			@(posedge hclk);
			{hresetn, loff_n, single} <= {1'b0, m != 1, m == 2};
			repeat (6) @(posedge hclk);
			hresetn <= 1'b1;
			{nrd, nwr} = 64'h0;
			mem.delete();
			repeat (8) @(posedge hclk);
			bus(1'b1, 32'h04, 32'hFFFF_FFFF);
			bus(1'b0, 32'h04, 32'h0);
			chk(rd, {29'h0, loff_n, single, 1'b1});
			bus(1'b0, 32'h00, 32'h0);
			chk(rd, 32'h1);
			bus(1'b0, 32'h14, 32'h0);
			chk(rd, 32'h0);
			for (int i = 0; i < 8; i++) begin
				seed = xs(seed);
				al[i] = {seed[7:3], 3'(i)};
				mwr(al[i], {seed[3:0], seed}, 4'h0, 1'b1);
			end
			for (int i = 0; i < 8; i++) begin
				seed = xs(seed);
				mwr(al[i], {seed, seed[31:28]}, seed[3:0], 1'b1);
			end
			seed = xs(seed);
			mwr(al[0], {seed[3:0], seed}, 4'h6, 1'b1);
			mrd(al[0]);
			settle();
			bus(1'b1, 32'h00, 32'h0);
			mwr(al[1], 36'h0, 4'h0, 1'b0);
			settle();
			bus(1'b1, 32'h00, 32'h1);
			for (int i = 0; i < 8; i++) mrd(al[i]);
			settle();
			chk(u_dss_ctl_model.got.size(), expq.size());
			while (expq.size() != 0)
				chk(u_dss_ctl_model.got.pop_front(), expq.pop_front());
			u_dss_ctl_model.got.delete();
			bus(1'b0, 32'h08, 32'h0);
			chk(rd, 32'(nrd));
			bus(1'b0, 32'h0C, 32'h0);
			chk(rd, 32'(nwr));
		end
		conclude();
	end
endmodule : ddr_sio_sram_port_bench
bind dss_port dss_port_assertions u_dss_port_assertions (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .k(k), .c(c), .c_n(c_n),
	.transaction_strobe_n(transaction_strobe_n), .rw(rw), .q_oe(q_oe),
	.echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n));
`default_nettype wire
